// >>> msc_serial_port.sv
// msc_serial_port: ascii command interpreter of the meter serial port
// assumes readings and panel inputs are synchronous to core_clk_in
// Functional notes
// - baud 300 to 19200, default 9600
// - parity 0 none, 1 odd, 2 even
// - stop bits 0 one, 1 two
// - device address held, default 001
// - panel changes comms only when unlocked
// - printout delay paces continuous printout
// - reading codes return unfiltered, peak, valley, filtered
// - item suffix selects fixed byte count
// - single-byte config items are written and read as a whole byte
// - dual items pack high and low nibble
`timescale 1ns/1ps
module msc_serial_port
  import msc_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEFAULT,
  parameter int TICK_CYCLES = CLK_HZ_DEFAULT / 1000 * PRINT_TICK_MS
)(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // serial line
  input wire logic rx_in,
  output logic tx_out,
  // front panel
  input wire logic panel_write_in,
  input wire logic comms_lockout_in,
  input wire logic [2:0] panel_baud_in,
  input wire logic [1:0] panel_parity_in,
  input wire logic panel_stop_in,
  input wire logic [7:0] panel_addr_in,
  input wire logic [15:0] panel_print_delay_in,
  input wire logic cont_print_in,
  // readings
  input wire logic [23:0] unfiltered_reading_in,
  input wire logic [23:0] peak_reading_in,
  input wire logic [23:0] valley_reading_in,
  input wire logic [23:0] filtered_reading_in,
  // setup outputs
  output logic [3:0] decimal_point_out,
  output logic [3:0] count_step_out,
  output logic [3:0] filter_config_out,
  output logic [3:0] filter_time_out,
  output logic [7:0] reading_flags_out,
  output logic [7:0] setpoint_flags_out,
  output logic cmd_error_out
);
  typedef struct packed {
    msc_state_t state;
    logic [2:0] baud;
    logic [1:0] parity;
    logic stop2;
    logic [7:0] dev_addr;
    logic [15:0] print_delay;
    logic [7:0] addr_acc;
    logic [6:0] prefix;
    logic [7:0] suffix;
    logic [23:0] data;
    logic [3:0] nchar;
    logic bad;
    logic [7:0][6:0] resp;
    logic [3:0] resp_len;
    logic [3:0] resp_idx;
    logic [31:0] tick_cnt;
    logic [15:0] print_cnt;
    logic print_due;
    logic [7:0] dp_cs;
    logic [7:0] fil;
    logic [7:0] rdg_flags;
    logic [7:0] sp_flags;
    logic cmd_err;
  } msc_core_t;

  msc_core_t st;
  msc_core_t next_st;
  msc_ser_if ser ();
  logic mem_wr;
  logic [23:0] mem_rd;
  logic [4:0] hv;
  logic [1:0] nb;
  logic err;
  logic rq_ok;
  logic [23:0] rq_val;

  msc_serial u_serial (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .rx_in(rx_in),
    .tx_out(tx_out),
    .ser(ser)
  );

  msc_setup_mem u_mem (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .wr_en_in(mem_wr),
    .idx_in(st.suffix[4:0]),
    .wr_data_in(st.data),
    .rd_data_out(mem_rd)
  );

  assign ser.bit_div = bit_div(CLK_HZ, st.baud);
  assign ser.parity = st.parity;
  assign ser.stop2 = st.stop2;
  assign ser.tx_valid = (st.state == S_SEND);
  assign ser.tx_char = st.resp[st.resp_idx[2:0]];

  always_comb
  begin
    next_st = st;
    next_st.cmd_err = 1'b0;
    mem_wr = 1'b0;
    err = 1'b0;
    hv = hex_val(ser.rx_char);
    nb = item_bytes(st.suffix);
    rq_ok = 1'b1;
    case (st.suffix)
      RQ_UNFILTERED: rq_val = unfiltered_reading_in;
      RQ_PEAK: rq_val = peak_reading_in;
      RQ_VALLEY: rq_val = valley_reading_in;
      RQ_FILTERED: rq_val = filtered_reading_in;
      default:
      begin
        rq_val = 24'h000000;
        rq_ok = 1'b0;
      end
    endcase
    if (panel_write_in && !comms_lockout_in)
    begin
      next_st.baud = panel_baud_in;
      next_st.parity = panel_parity_in;
      next_st.stop2 = panel_stop_in;
      next_st.dev_addr = panel_addr_in;
      next_st.print_delay = panel_print_delay_in;
    end
    case (st.state)
      S_IDLE:
        if (st.print_due && cont_print_in)
        begin
          next_st.print_due = 1'b0;
          next_st.resp = hex_reply(filtered_reading_in, 2'h3);
          next_st.resp_len = 4'h7;
          next_st.resp_idx = 4'h0;
          next_st.state = S_SEND;
        end else if (ser.rx_valid && ser.rx_char == CH_RECOG) next_st.state = S_ADDR_HI;
        else if (ser.rx_valid && ser.rx_char == CH_SETUP_LEAD) next_st.state = S_SETUP_E;
      S_SETUP_E:
        if (ser.rx_valid)
        begin
          next_st.prefix = ser.rx_char;
          next_st.state = (ser.rx_char == CH_SETUP_TAIL) ? S_EXEC : S_IDLE;
        end
      S_ADDR_HI:
        if (ser.rx_valid)
        begin
          next_st.addr_acc = {hv[3:0], 4'h0};
          next_st.state = hv[4] ? S_ADDR_LO : S_IDLE;
        end
      S_ADDR_LO:
        if (ser.rx_valid)
        begin
          // a foreign address drops the command silently
          if (hv[4] && {st.addr_acc[7:4], hv[3:0]} == st.dev_addr) next_st.state = S_PREFIX;
          else next_st.state = S_IDLE;
        end
      S_PREFIX:
        if (ser.rx_valid)
        begin
          next_st.prefix = ser.rx_char;
          next_st.data = 24'h000000;
          next_st.nchar = 4'h0;
          next_st.bad = 1'b0;
          next_st.state = S_SUF_HI;
        end
      S_SUF_HI:
        if (ser.rx_valid)
        begin
          next_st.suffix[7:4] = hv[3:0];
          next_st.bad = !hv[4];
          next_st.state = S_SUF_LO;
        end
      S_SUF_LO:
        if (ser.rx_valid)
        begin
          next_st.suffix[3:0] = hv[3:0];
          next_st.bad = st.bad || !hv[4];
          next_st.state = S_DATA;
        end
      S_DATA:
        if (ser.rx_valid)
        begin
          if (ser.rx_char == CH_CR) next_st.state = S_EXEC;
          else if (ser.rx_char == CH_RECOG) next_st.state = S_ADDR_HI;
          else if (hv[4] && st.nchar < 4'h6)
          begin
            next_st.data = {st.data[19:0], hv[3:0]};
            next_st.nchar = st.nchar + 1'b1;
          end else next_st.bad = 1'b1;
        end
      S_EXEC:
      begin
        next_st.state = S_SEND;
        next_st.resp_idx = 4'h0;
        next_st.resp = {8{CH_CR}};
        next_st.resp_len = 4'h1;
        if (st.prefix == CH_SETUP_TAIL)
        begin
          next_st.resp[0] = to_hex(st.dev_addr[7:4]);
          next_st.resp[1] = to_hex(st.dev_addr[3:0]);
          next_st.resp[2] = to_hex({1'b0, st.baud});
          next_st.resp[3] = to_hex({1'b0, st.parity, st.stop2});
          next_st.resp_len = 4'h5;
        end else if (st.bad) err = 1'b1;
        else if (st.prefix == CH_X)
        begin
          if (rq_ok && st.nchar == 4'h0)
          begin
            next_st.resp = hex_reply(rq_val, 2'h3);
            next_st.resp_len = 4'h7;
          end else err = 1'b1;
        end else if (st.prefix == CH_W)
        begin
          if (nb != 2'h0 && st.nchar == {1'b0, nb, 1'b0})
          begin
            mem_wr = 1'b1;
            case (st.suffix)
              OFS_DECIMAL_POINT_AND_COUNT_STEP: next_st.dp_cs = st.data[7:0];
              OFS_FILTER_SETUP_AND_TIME: next_st.fil = st.data[7:0];
              OFS_READING_SETUP_FLAGS: next_st.rdg_flags = st.data[7:0];
              OFS_SETPOINT_PAIR_LOW_SETUP: next_st.sp_flags = st.data[7:0];
              default: next_st.fil = st.fil;
            endcase
          end else err = 1'b1;
        end else if (st.prefix == CH_R || st.prefix == CH_G || st.prefix == CH_P)
        begin
          if (nb != 2'h0 && st.nchar == 4'h0)
          begin
            next_st.resp = hex_reply(mem_rd, nb);
            next_st.resp_len = {1'b0, nb, 1'b1};
          end else err = 1'b1;
        end else err = 1'b1;
        if (err)
        begin
          next_st.resp[0] = CH_QMARK;
          next_st.resp[1] = CH_C;
          next_st.resp_len = 4'h3;
          next_st.cmd_err = 1'b1;
        end
      end
      S_SEND:
        if (ser.tx_ready)
        begin
          if (st.resp_idx == st.resp_len - 1'b1) next_st.state = S_IDLE;
          else next_st.resp_idx = st.resp_idx + 1'b1;
        end
      default: next_st.state = S_IDLE;
    endcase
    // tick divider paces the printout; a new due flag beats its clear above
    if (cont_print_in)
    begin
      if (st.tick_cnt == 32'(TICK_CYCLES - 1))
      begin
        next_st.tick_cnt = 32'h00000000;
        if (st.print_cnt >= st.print_delay)
        begin
          next_st.print_cnt = 16'h0000;
          next_st.print_due = 1'b1;
        end else next_st.print_cnt = st.print_cnt + 1'b1;
      end else next_st.tick_cnt = st.tick_cnt + 1'b1;
    end else begin
      next_st.tick_cnt = 32'h00000000;
      next_st.print_cnt = 16'h0000;
      next_st.print_due = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      st <= '0;
      st.state <= S_IDLE;
      st.baud <= BAUD_DEFAULT;
      st.parity <= PAR_NONE;
      st.stop2 <= STOP_ONE;
      st.dev_addr <= ADDR_DEFAULT;
      st.resp <= {8{CH_CR}};
      st.resp_len <= 4'h1;
    end else st <= next_st;
  end

  assign decimal_point_out = st.dp_cs[7:4];
  assign count_step_out = st.dp_cs[3:0];
  assign filter_config_out = st.fil[7:4];
  assign filter_time_out = st.fil[3:0];
  assign reading_flags_out = st.rdg_flags;
  assign setpoint_flags_out = st.sp_flags;
  assign cmd_error_out = st.cmd_err;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence addr_lo_seen;
    st.state == S_ADDR_LO && ser.rx_valid;
  endsequence
  sequence addr_miss;
    addr_lo_seen ##0 (!hv[4] || {st.addr_acc[7:4], hv[3:0]} != st.dev_addr);
  endsequence

  baud_default_a: assert property ($fell(srst_in) |-> ser.bit_div == bit_div(CLK_HZ, BAUD_9600))
    else $error("baud divisor not at default after reset");
  parity_load_a: assert property (panel_write_in && !comms_lockout_in |=> st.parity == $past(panel_parity_in))
    else $error("panel parity not taken");
  stop_load_a: assert property (panel_write_in && !comms_lockout_in |=> ser.stop2 == $past(panel_stop_in))
    else $error("panel stop bits not taken");
  addr_default_a: assert property ($fell(srst_in) |-> st.dev_addr == 8'h01)
    else $error("device address not 001 after reset");
  lockout_hold_a: assert property (comms_lockout_in |=> $stable({st.baud, st.parity, st.stop2, st.dev_addr}))
    else $error("comms settings changed while locked");
  print_due_a: assert property (st.print_due && cont_print_in && st.state == S_IDLE |=> st.state == S_SEND ##0 st.resp_len == 4'h7)
    else $error("continuous printout not started");
  peak_pick_a: assert property (st.state == S_EXEC && st.prefix == CH_X && st.suffix == RQ_PEAK && st.nchar == 4'h0 && !st.bad |=> st.resp[1] == to_hex($past(peak_reading_in[19:16])))
    else $error("peak request not answered with peak");
  write_width_a: assert property (mem_wr |-> nb != 2'h0 && st.nchar == {1'b0, nb, 1'b0})
    else $error("item written with wrong byte count");
  flag_bits_a: assert property (mem_wr && st.suffix == OFS_READING_SETUP_FLAGS |=> reading_flags_out == $past(st.data[7:0]))
    else $error("reading flags not updated");
  nibble_split_a: assert property (mem_wr && st.suffix == OFS_FILTER_SETUP_AND_TIME |=> filter_config_out == $past(st.data[7:4]) && filter_time_out == $past(st.data[3:0]))
    else $error("dual item nibbles misplaced");
  bad_item_a: assert property (st.state == S_EXEC && st.prefix == CH_W && nb == 2'h0 |-> !mem_wr ##1 cmd_error_out && st.resp[0] == CH_QMARK)
    else $error("undefined item not refused");
  foreign_addr_a: assert property (addr_miss |=> (st.state == S_IDLE && !mem_wr) [*2])
    else $error("foreign address command not ignored");
endmodule : msc_serial_port

// >>> msc_pkg.sv
// msc_pkg: constants, item map and helper functions for the meter serial command port
// assumes 7-bit ascii characters and a single 200 MHz core clock
package msc_pkg;

  localparam int CLK_HZ_DEFAULT = 200_000_000;
  localparam int PRINT_TICK_MS = 100;
  localparam int DIV_W = 20;
  localparam int ITEM_DEPTH = 17;

  // baud selections, 300 up to 19200
  localparam logic [2:0] BAUD_300 = 3'h0;
  localparam logic [2:0] BAUD_600 = 3'h1;
  localparam logic [2:0] BAUD_1200 = 3'h2;
  localparam logic [2:0] BAUD_2400 = 3'h3;
  localparam logic [2:0] BAUD_4800 = 3'h4;
  localparam logic [2:0] BAUD_9600 = 3'h5;
  localparam logic [2:0] BAUD_19200 = 3'h6;
  localparam logic [2:0] BAUD_DEFAULT = BAUD_9600;

  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic STOP_ONE = 1'b0;
  localparam logic STOP_TWO = 1'b1;
  localparam logic [7:0] ADDR_DEFAULT = 8'h01;

  localparam logic [6:0] CH_RECOG = 7'h2a;
  localparam logic [6:0] CH_SETUP_LEAD = 7'h01;
  localparam logic [6:0] CH_SETUP_TAIL = 7'h45;
  localparam logic [6:0] CH_CR = 7'h0d;
  localparam logic [6:0] CH_G = 7'h47;
  localparam logic [6:0] CH_P = 7'h50;
  localparam logic [6:0] CH_R = 7'h52;
  localparam logic [6:0] CH_W = 7'h57;
  localparam logic [6:0] CH_X = 7'h58;
  localparam logic [6:0] CH_QMARK = 7'h3f;
  localparam logic [6:0] CH_C = 7'h43;

  // setup item suffixes
  localparam logic [7:0] OFS_INSTRUMENT_CLASS = 8'h01;
  localparam logic [7:0] OFS_SCALE_STEP_SIZE = 8'h02;
  localparam logic [7:0] OFS_UPPER_CAPACITY_LIMIT = 8'h03;
  localparam logic [7:0] OFS_LOWER_CAPACITY_LIMIT = 8'h04;
  localparam logic [7:0] OFS_MEASUREMENT_UNIT = 8'h05;
  localparam logic [7:0] OFS_READING_SETUP_FLAGS = 8'h06;
  localparam logic [7:0] OFS_READING_SCALE_FACTOR = 8'h07;
  localparam logic [7:0] OFS_READING_OFFSET_VALUE = 8'h08;
  localparam logic [7:0] OFS_INPUT_SETUP_FLAGS = 8'h09;
  localparam logic [7:0] OFS_INPUT_SCALE_FACTOR = 8'h0a;
  localparam logic [7:0] OFS_TARE_SETUP_FLAGS = 8'h0b;
  localparam logic [7:0] OFS_DECIMAL_POINT_AND_COUNT_STEP = 8'h0c;
  localparam logic [7:0] OFS_FILTER_SETUP_AND_TIME = 8'h0e;
  localparam logic [7:0] OFS_SETPOINT_PAIR_LOW_SETUP = 8'h10;

  localparam logic [7:0] RQ_UNFILTERED = 8'h01;
  localparam logic [7:0] RQ_PEAK = 8'h02;
  localparam logic [7:0] RQ_VALLEY = 8'h03;
  localparam logic [7:0] RQ_FILTERED = 8'h04;

  typedef enum logic [3:0] {
    S_IDLE, S_SETUP_E, S_ADDR_HI, S_ADDR_LO, S_PREFIX, S_SUF_HI, S_SUF_LO, S_DATA, S_EXEC, S_SEND
  } msc_state_t;

  function automatic logic [DIV_W-1:0] bit_div(input int clk_hz, input logic [2:0] code);
    int rate;
    case (code)
      BAUD_300: rate = 300;
      BAUD_600: rate = 600;
      BAUD_1200: rate = 1200;
      BAUD_2400: rate = 2400;
      BAUD_4800: rate = 4800;
      BAUD_19200: rate = 19200;
      default: rate = 9600;
    endcase
    return DIV_W'(clk_hz / rate);
  endfunction : bit_div

  // data bytes carried by an item, zero for an undefined suffix
  function automatic logic [1:0] item_bytes(input logic [7:0] suf);
    case (suf)
      OFS_INSTRUMENT_CLASS, OFS_READING_SETUP_FLAGS, OFS_INPUT_SETUP_FLAGS, OFS_TARE_SETUP_FLAGS,
      OFS_DECIMAL_POINT_AND_COUNT_STEP, OFS_FILTER_SETUP_AND_TIME,
      OFS_SETPOINT_PAIR_LOW_SETUP: return 2'h1;
      OFS_SCALE_STEP_SIZE: return 2'h2;
      OFS_UPPER_CAPACITY_LIMIT, OFS_LOWER_CAPACITY_LIMIT, OFS_MEASUREMENT_UNIT,
      OFS_READING_SCALE_FACTOR, OFS_READING_OFFSET_VALUE,
      OFS_INPUT_SCALE_FACTOR: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction : item_bytes

  function automatic logic [6:0] to_hex(input logic [3:0] n);
    return (n < 4'ha) ? 7'h30 + {3'h0, n} : 7'h37 + {3'h0, n};
  endfunction : to_hex

  // {valid, nibble}
  function automatic logic [4:0] hex_val(input logic [6:0] c);
    if (c >= 7'h30 && c <= 7'h39) return {1'b1, 4'(c - 7'h30)};
    if (c >= 7'h41 && c <= 7'h46) return {1'b1, 4'(c - 7'h37)};
    if (c >= 7'h61 && c <= 7'h66) return {1'b1, 4'(c - 7'h57)};
    return 5'h00;
  endfunction : hex_val

  // nb bytes as 2*nb hex characters, high nibble first, then carriage return
  function automatic logic [7:0][6:0] hex_reply(input logic [23:0] v, input logic [1:0] nb);
    logic [23:0] al;
    logic [7:0][6:0] r;
    case (nb)
      2'h1: al = {v[7:0], 16'h0000};
      2'h2: al = {v[15:0], 8'h00};
      default: al = v;
    endcase
    r = {8{CH_CR}};
    for (int i = 0; i < 6; i++)
      if (i < 2 * int'(nb)) r[i] = to_hex(al[23-4*i -: 4]);
    return r;
  endfunction : hex_reply

endpackage : msc_pkg

// >>> msc_ser_if.sv
// msc_ser_if: character link between the command core and the serial framer
// assumes both ends on core_clk_in
`timescale 1ns/1ps
interface msc_ser_if;
  logic [19:0] bit_div;
  logic [1:0] parity;
  logic stop2;
  logic [6:0] rx_char;
  logic rx_valid;
  logic [6:0] tx_char;
  logic tx_valid;
  logic tx_ready;
  modport ctl (output bit_div, parity, stop2, tx_char, tx_valid, input rx_char, rx_valid, tx_ready);
  modport phy (input bit_div, parity, stop2, tx_char, tx_valid, output rx_char, rx_valid, tx_ready);
endinterface : msc_ser_if

// >>> msc_setup_mem.sv
// msc_setup_mem: setup item store, one 24-bit word per item suffix
// assumes write and read index are held stable by the caller
`timescale 1ns/1ps
module msc_setup_mem
  import msc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // access
  input wire logic wr_en_in,
  input wire logic [4:0] idx_in,
  input wire logic [23:0] wr_data_in,
  output logic [23:0] rd_data_out
);
  typedef struct packed {
    logic [ITEM_DEPTH-1:0][23:0] word;
    logic [23:0] rd;
  } msc_mem_t;

  msc_mem_t st;
  msc_mem_t next_st;

  always_comb
  begin
    next_st = st;
    if (wr_en_in && idx_in < 5'(ITEM_DEPTH)) next_st.word[idx_in] = wr_data_in;
    next_st.rd = (idx_in < 5'(ITEM_DEPTH)) ? st.word[idx_in] : 24'h000000;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in) st <= '0;
    else st <= next_st;
  end

  assign rd_data_out = st.rd;
endmodule : msc_setup_mem

// >>> msc_serial.sv
// msc_serial: async framer, 7 data bits, optional parity, one or two stop bits
// assumes rx_in is already synchronous to core_clk_in
`timescale 1ns/1ps
module msc_serial
  import msc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // line
  input wire logic rx_in,
  output logic tx_out,
  // core side
  msc_ser_if.phy ser
);
  typedef struct packed {
    logic rx_on;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [9:0] rx_sh;
    logic rx_valid;
    logic [6:0] rx_char;
    logic tx_on;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic line;
  } msc_ser_t;

  msc_ser_t st;
  msc_ser_t next_st;
  logic par_en;
  logic [6:0] rx_d;
  logic [9:0] frame;

  always_comb
  begin
    next_st = st;
    next_st.rx_valid = 1'b0;
    par_en = (ser.parity == PAR_ODD) || (ser.parity == PAR_EVEN);
    // data sits just above the start sample, parity bit (if any) on top
    rx_d = par_en ? st.rx_sh[8:2] : st.rx_sh[9:3];
    frame = par_en ? {2'b11, (ser.parity == PAR_ODD) ? ~^ser.tx_char : ^ser.tx_char, ser.tx_char}
                   : {3'b111, ser.tx_char};
    // receive: half-bit delay centres every sample; rx_cnt reaching zero is the bit enable
    if (!st.rx_on)
    begin
      if (!rx_in)
      begin
        next_st.rx_on = 1'b1;
        next_st.rx_cnt = ser.bit_div >> 1;
        next_st.rx_bit = 4'h0;
      end
    end else if (st.rx_cnt != '0) next_st.rx_cnt = st.rx_cnt - 1'b1;
    else if (st.rx_bit == 4'h0 && rx_in) next_st.rx_on = 1'b0;
    else if (st.rx_bit == 4'(8 + int'(par_en)))
    begin
      // stop sample; framing or parity failure drops the character
      next_st.rx_on = 1'b0;
      next_st.rx_valid = rx_in && (!par_en || ((^rx_d ^ st.rx_sh[9]) == (ser.parity == PAR_ODD)));
      next_st.rx_char = rx_d;
    end else
    begin
      next_st.rx_sh = {rx_in, st.rx_sh[9:1]};
      next_st.rx_bit = st.rx_bit + 1'b1;
      next_st.rx_cnt = ser.bit_div - 1'b1;
    end
    // transmit
    if (!st.tx_on)
    begin
      next_st.line = 1'b1;
      if (ser.tx_valid)
      begin
        next_st.tx_on = 1'b1;
        next_st.line = 1'b0;
        next_st.tx_sh = frame;
        next_st.tx_bit = 4'(8 + int'(par_en) + int'(ser.stop2 == STOP_TWO));
        next_st.tx_cnt = ser.bit_div - 1'b1;
      end
    end else if (st.tx_cnt != '0) next_st.tx_cnt = st.tx_cnt - 1'b1;
    else if (st.tx_bit == 4'h0)
    begin
      next_st.tx_on = 1'b0;
      next_st.line = 1'b1;
    end else
    begin
      next_st.line = st.tx_sh[0];
      next_st.tx_sh = {1'b1, st.tx_sh[9:1]};
      next_st.tx_bit = st.tx_bit - 1'b1;
      next_st.tx_cnt = ser.bit_div - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in) st <= '{line: 1'b1, default: '0};
    else st <= next_st;
  end

  assign tx_out = st.line;
  assign ser.tx_ready = !st.tx_on;
  assign ser.rx_valid = st.rx_valid;
  assign ser.rx_char = st.rx_char;
endmodule : msc_serial

// >>> msc_host_model.sv
// msc_host_model: host computer at the far end of the serial line
// assumes 7 data bits a character, bit time counted in core clocks
`timescale 1ns/1ps
module msc_host_model (
  // clock
  input wire logic core_clk_in,
  // line
  input wire logic line_in,
  output logic line_out
);
  int bit_n = 10;
  logic [1:0] par = 2'h0;
  logic stop2 = 1'b0;
  logic [6:0] rc;
  logic [6:0] got[$];
  initial line_out = 1'b1;
  task automatic hold(input logic b);
    line_out = b;
    repeat (bit_n) @(negedge core_clk_in);
  endtask : hold
  // prefix and address are up to the caller
  task automatic put(input logic [6:0] c);
    hold(1'b0);
    for (int i = 0; i < 7; i++) hold(c[i]);
    if (par != 2'h0) hold(^c ^ (par == 2'h1));
    hold(1'b1);
    if (stop2) hold(1'b1);
  endtask : put
  // a broken stop bit is kept as 7f so that the compare fails
  always @(negedge line_in)
  begin
    repeat (bit_n / 2) @(posedge core_clk_in);
    for (int i = 0; i < 7; i++)
    begin
      repeat (bit_n) @(posedge core_clk_in);
      rc[i] = line_in;
    end
    repeat (bit_n * ((par != 2'h0) ? 2 : 1)) @(posedge core_clk_in);
    got.push_back(line_in ? rc : 7'h7f);
  end
endmodule : msc_host_model

// >>> msc_serial_port_tb.sv
// msc_serial_port_tb: self-checking bench of the meter serial command port
// assumes the host model on the line and a lowered clock rate for speed
`timescale 1ns/1ps
module msc_serial_port_tb
  import msc_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic rx, tx, err, pw = 1'b0, lock = 1'b1, cp = 1'b0, stop = 1'b0;
  logic [2:0] baud = 3'h5;
  logic [1:0] par = 2'h0;
  logic [7:0] addr = 8'h01, rf, sf;
  logic [15:0] pd = 16'h0002;
  logic [23:0] rd[4] = '{24'hab12cd, 24'h3e4f50, 24'h0019c7, 24'hd2e8f1};
  logic [3:0] dp, cs, fc, ft;
  int num_errors = 0, checks_done = 0, cyc = 0, errs = 0;
  msc_serial_port #(.CLK_HZ(96000), .TICK_CYCLES(10)) dut (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .rx_in(rx), .tx_out(tx),
    .panel_write_in(pw), .comms_lockout_in(lock), .panel_baud_in(baud),
    .panel_parity_in(par), .panel_stop_in(stop), .panel_addr_in(addr),
    .panel_print_delay_in(pd), .cont_print_in(cp), .unfiltered_reading_in(rd[0]),
    .peak_reading_in(rd[1]), .valley_reading_in(rd[2]), .filtered_reading_in(rd[3]),
    .decimal_point_out(dp), .count_step_out(cs), .filter_config_out(fc),
    .filter_time_out(ft), .reading_flags_out(rf), .setpoint_flags_out(sf),
    .cmd_error_out(err));
  msc_host_model host (.core_clk_in(core_clk_in), .line_in(tx), .line_out(rx));
  initial forever #2.5 core_clk_in = ~core_clk_in;
  always @(negedge core_clk_in) if (err === 1'b1) errs++;
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic string hx(input logic [23:0] v);
    string r;
    r = $sformatf("%h\015", v);
    return r.toupper();
  endfunction : hx
  // exact also forbids trailing characters after the reply
  task automatic run(input string s, input string e, input bit exact = 1'b1);
    int t;
    t = 0;
    host.got.delete();
    foreach (s[i]) host.put(7'(s[i]));
    while (host.got.size() < e.len() && t < 3000)
    begin
      @(negedge core_clk_in);
      t++;
    end
    if (exact) repeat (host.bit_n * 12) @(negedge core_clk_in);
    // a reply that never comes counts in both modes; only exact also forbids extras
    check("reply length", 24'(exact || host.got.size() < e.len() ? host.got.size() : e.len()),
          24'(e.len()));
    for (int i = 0; i < e.len() && i < host.got.size(); i++)
      check("reply char", 24'(host.got[i]), 24'(e[i]));
  endtask : run
  task automatic panel(input logic lk, input logic [2:0] b, input logic [1:0] p,
                       input logic s, input logic [7:0] a);
    lock = lk;
    baud = b;
    par = p;
    stop = s;
    addr = a;
    pw = 1'b1;
    @(negedge core_clk_in);
    pw = 1'b0;
  endtask : panel
  task automatic t_reset();
    check("tx idle", 24'(tx), 24'h1);
    check("nibbles", 24'({dp, cs, fc, ft}), 24'h0);
    check("flags", 24'({rf, sf, err}), 24'h0);
    run("\001E", "0150\015");
  endtask : t_reset
  task automatic t_items();
    for (int n = 1; n <= 4; n++) run($sformatf("*01X0%0d\015", n), hx(rd[n - 1]));
    run("*01X05\015", "?C\015");
    run("*01W0CA5\015", "\015");
    check("dec point", 24'({dp, cs}), 24'ha5);
    run("*01W0E7B\015", "\015");
    check("filter", 24'({fc, ft}), 24'h7b);
    run("*01W063C\015", "\015");
    check("rdg flags", 24'(rf), 24'h3c);
    run("*01W1081\015", "\015");
    check("sp flags", 24'(sf), 24'h81);
    run("*01P10\015", "81\015");
    run("*01W03A1B2C3\015", "\015");
    run("*01R03\015", "A1B2C3\015");
    run("*01G02\015", "0000\015");
    run("*01W0D\015", "?C\015");
    run("*01R0F\015", "?C\015");
    check("error pulses", 24'(errs), 24'h3);
    check("sp flags kept", 24'(sf), 24'h81);
  endtask : t_items
  task automatic t_ignored();
    run("01X01\015", "");
    run("*02X01\015", "");
  endtask : t_ignored
  task automatic t_panel();
    panel(1'b1, 3'h6, 2'h2, 1'b1, 8'h23);
    run("\001E", "0150\015");
    panel(1'b0, 3'h6, 2'h2, 1'b1, 8'h23);
    host.bit_n = 5;
    host.par = 2'h2;
    host.stop2 = 1'b1;
    run("\001E", "2365\015");
    run("*23X04\015", hx(rd[3]));
    panel(1'b0, 3'h5, 2'h1, 1'b0, 8'h01);
    host.bit_n = 10;
    host.par = 2'h1;
    host.stop2 = 1'b0;
    run("\001E", "0152\015");
  endtask : t_panel
  task automatic t_print();
    cp = 1'b1;
    run("", hx(rd[3]), 1'b0);
    cp = 1'b0;
  endtask : t_print
  initial
  begin
    repeat (12) @(negedge core_clk_in);
    srst_in = 1'b0;
    t_reset();
    t_items();
    t_ignored();
    t_panel();
    t_print();
    test_done();
  end
endmodule : msc_serial_port_tb
